// ### hdl/dmd_core.sv
// Purpose: debug halt control, control register and byte command engine
// Assumes: rx/tx bytes framed elsewhere; memories answer in the cycle after a read
// Notes: one command at a time; tx byte is held until tx_ready
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "dmd_defines.svh"
module dmd_core
    import dmd_pkg::*;
#(
    parameter int PROG_AW = 12
)(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        por_brownout,
    input  wire logic        sys_reset_active,
    input  wire logic        debug_wire_pin_in,
    input  wire logic        stop_mode,
    input  wire logic        wdt_enable,
    input  wire logic        read_protect,
    input  wire logic        break_opcode_decoded,
    input  wire logic        ocd_exec_req,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    output logic      [7:0]  tx_byte,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [15:0] mem_addr,
    output logic             prog_rd,
    input  wire logic [7:0]  prog_rdata,
    output logic             data_rd,
    output logic             data_wr,
    output logic      [7:0]  data_wdata,
    input  wire logic [7:0]  data_rdata,
    output logic             fetch_enable,
    output logic             sys_clk_run,
    output logic             periph_run,
    output logic             halt_exit,
    output logic             wdt_refresh,
    output logic             soft_reset_out
);
    // ===========================================
    // control register and halt state
    logic             halt_q,  halt_d;
    logic             brk_q,   brk_d;
    logic             ack_q,   ack_d;
    logic             srst_q,  srst_d;
    logic [4:0]       srst_cnt_q, srst_cnt_d;
    logic             rst_seen_q, rst_seen_d;
    logic             pin_last_q, pin_last_d;
    logic             brk_hit;
    logic             ack_req;

    assign brk_hit = break_opcode_decoded & brk_q & ~halt_q;

    always_comb
    begin
        halt_d     = halt_q;
        brk_d      = brk_q;
        ack_d      = ack_q;
        srst_d     = srst_q;
        srst_cnt_d = srst_cnt_q;
        rst_seen_d = sys_reset_active;
        pin_last_d = sys_reset_active ? debug_wire_pin_in : pin_last_q;
        ack_req    = 1'b0;
        if (reg_wr && reg_addr == `DMD_ADDR_CTRL)
        begin
            brk_d = reg_wdata[`DMD_BIT_BRK];
            ack_d = reg_wdata[`DMD_BIT_ACK];
            if (reg_wdata[`DMD_BIT_HALT])
                halt_d = 1'b1;
            else if (!read_protect)
                halt_d = 1'b0;
            if (reg_wdata[`DMD_BIT_SRST] && !srst_q)
            begin
                srst_d     = 1'b1;
                srst_cnt_d = 5'(`DMD_SRST_CYCLES);
            end
        end
        if (srst_q)
        begin
            srst_cnt_d = srst_cnt_q - 5'd1;
            if (srst_cnt_q == 5'd1)
                srst_d = 1'b0;
        end
        // reset end: pin level of the last reset cycle decides debug entry
        if (rst_seen_q && !sys_reset_active && !pin_last_q)
            halt_d = 1'b1;
        if (brk_hit)
        begin
            halt_d  = 1'b1;
            ack_req = ack_q;
        end
        if (por_brownout)
            halt_d = 1'b0;
    end

    // ===========================================
    // command engine
    dmd_state_e       st_q, st_d;
    logic [7:0]       cmd_q, cmd_d;
    logic [15:0]      addr_q, addr_d;
    logic [16:0]      cnt_q, cnt_d;
    logic [15:0]      crc_q, crc_d;
    logic             rdwait_q, rdwait_d;
    logic [7:0]       txb_q, txb_d;
    logic             txv_q, txv_d;
    logic             prd_q, prd_d;
    logic             drd_q, drd_d;
    logic             dwr_q, dwr_d;
    logic [7:0]       dwd_q, dwd_d;
    logic             tx_free;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (r[15] ^ b[i]) ? ((r << 1) ^ `DMD_CRC_POLY) : (r << 1);
        return r;
    endfunction

    assign tx_free = ~txv_q | tx_ready;

    always_comb
    begin
        st_d     = st_q;
        cmd_d    = cmd_q;
        addr_d   = addr_q;
        cnt_d    = cnt_q;
        crc_d    = crc_q;
        // memory answers the cycle after the strobe, so sample one cycle later
        rdwait_d = prd_q | drd_q;
        txb_d    = txb_q;
        txv_d    = txv_q & ~tx_ready;
        prd_d    = 1'b0;
        drd_d    = 1'b0;
        dwr_d    = 1'b0;
        dwd_d    = dwd_q;
        // step only after the write has gone out on mem_addr
        if (dwr_q)
            addr_d = addr_q + 16'd1;
        unique case (st_q)
            DMD_IDLE:
                if (ack_req && tx_free)
                begin
                    txb_d = `DMD_FILL_BYTE;
                    txv_d = 1'b1;
                end
                else if (rx_valid)
                begin
                    cmd_d = rx_byte;
                    if (rx_byte == `DMD_CMD_CRC)
                    begin
                        st_d   = DMD_CRC_RUN;
                        addr_d = 16'h0000;
                        crc_d  = `DMD_CRC_SEED;
                        cnt_d  = 17'(1 << PROG_AW);
                    end
                    else if (rx_byte >= `DMD_CMD_RD_PROG && rx_byte <= `DMD_CMD_RD_DATA)
                        st_d = DMD_AH;
                end
            DMD_AH:
                if (rx_valid)
                begin
                    addr_d[15:8] = rx_byte;
                    st_d         = DMD_AL;
                end
            DMD_AL:
                if (rx_valid)
                begin
                    addr_d[7:0] = rx_byte;
                    st_d        = DMD_SH;
                end
            DMD_SH:
                if (rx_valid)
                begin
                    cnt_d[15:8] = rx_byte;
                    st_d        = DMD_SL;
                end
            DMD_SL:
                if (rx_valid)
                begin
                    cnt_d = {({cnt_q[15:8], rx_byte} == 16'h0000), cnt_q[15:8], rx_byte};
                    st_d  = DMD_XFER;
                end
            DMD_XFER:
                if (cmd_q == `DMD_CMD_WR_DATA)
                begin
                    if (rx_valid)
                    begin
                        dwr_d  = halt_q & ~read_protect;
                        dwd_d  = rx_byte;
                        cnt_d  = cnt_q - 17'd1;
                        if (cnt_q == 17'd1)
                            st_d = DMD_IDLE;
                    end
                end
                else if (rdwait_q)
                begin
                    txv_d = 1'b1;
                    if (cmd_q == `DMD_CMD_RD_PROG)
                        txb_d = (halt_q && !read_protect) ? prog_rdata : `DMD_FILL_BYTE;
                    else
                        txb_d = halt_q ? data_rdata : `DMD_FILL_BYTE;
                    addr_d = addr_q + 16'd1;
                    cnt_d  = cnt_q - 17'd1;
                    if (cnt_q == 17'd1)
                        st_d = DMD_IDLE;
                end
                else if (tx_free && !prd_q && !drd_q)
                begin
                    prd_d    = (cmd_q == `DMD_CMD_RD_PROG);
                    drd_d    = (cmd_q == `DMD_CMD_RD_DATA);
                end
            DMD_CRC_RUN:
                // result withheld until the whole array has been scanned
                if (rdwait_q)
                begin
                    crc_d  = crc_byte(crc_q, prog_rdata);
                    addr_d = addr_q + 16'd1;
                    cnt_d  = cnt_q - 17'd1;
                    if (cnt_q == 17'd1)
                        st_d = DMD_CRC_HI;
                end
                else if (!prd_q)
                begin
                    prd_d    = 1'b1;
                end
            DMD_CRC_HI:
                if (tx_free)
                begin
                    if (!halt_q)
                        crc_d = `DMD_CRC_NONE;
                    txb_d = halt_q ? crc_q[15:8] : `DMD_FILL_BYTE;
                    txv_d = 1'b1;
                    st_d  = DMD_CRC_LO;
                end
            DMD_CRC_LO:
                if (tx_free)
                begin
                    txb_d = crc_q[7:0];
                    txv_d = 1'b1;
                    st_d  = DMD_IDLE;
                end
        endcase
    end

    // ===========================================
    // registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            halt_q     <= 1'b0;
            brk_q      <= 1'b0;
            ack_q      <= 1'b0;
            srst_q     <= 1'b0;
            srst_cnt_q <= 5'd0;
            rst_seen_q <= 1'b0;
            pin_last_q <= 1'b1;
            st_q       <= DMD_IDLE;
            cmd_q      <= 8'h00;
            addr_q     <= 16'h0000;
            cnt_q      <= 17'h0_0000;
            crc_q      <= 16'h0000;
            rdwait_q   <= 1'b0;
            txb_q      <= 8'h00;
            txv_q      <= 1'b0;
            prd_q      <= 1'b0;
            drd_q      <= 1'b0;
            dwr_q      <= 1'b0;
            dwd_q      <= 8'h00;
            reg_rdata  <= 8'h00;
            fetch_enable <= 1'b1;
            sys_clk_run  <= 1'b1;
            periph_run   <= 1'b1;
            halt_exit    <= 1'b0;
            wdt_refresh  <= 1'b0;
        end
        else if (ce)
        begin
            halt_q     <= halt_d;
            brk_q      <= brk_d;
            ack_q      <= ack_d;
            srst_q     <= srst_d;
            srst_cnt_q <= srst_cnt_d;
            rst_seen_q <= rst_seen_d;
            pin_last_q <= pin_last_d;
            st_q       <= st_d;
            cmd_q      <= cmd_d;
            addr_q     <= addr_d;
            cnt_q      <= cnt_d;
            crc_q      <= crc_d;
            rdwait_q   <= rdwait_d;
            txb_q      <= txb_d;
            txv_q      <= txv_d;
            prd_q      <= prd_d;
            drd_q      <= drd_d;
            dwr_q      <= dwr_d;
            dwd_q      <= dwd_d;
            reg_rdata  <= 8'h00;
            if (reg_rd && reg_addr == `DMD_ADDR_CTRL)
                reg_rdata <= {halt_q, brk_q, ack_q, 4'h0, srst_q};
            else if (reg_rd && reg_addr == `DMD_ADDR_STATUS)
                reg_rdata <= {4'h0, st_q};
            fetch_enable <= ~halt_d | ocd_exec_req;
            sys_clk_run  <= ~stop_mode;
            periph_run   <= ~stop_mode;
            halt_exit    <= halt_d & ~halt_q;
            wdt_refresh  <= halt_d & wdt_enable;
        end
    end

    assign tx_byte        = txb_q;
    assign tx_valid       = txv_q;
    assign mem_addr       = addr_q;
    assign prog_rd        = prd_q;
    assign data_rd        = drd_q;
    assign data_wr        = dwr_q;
    assign data_wdata     = dwd_q;
    assign soft_reset_out = srst_q;
endmodule

// ### shared/dmd_defines.svh
// Purpose: constants for the debug-mode memory access block
// Assumes: 25 MHz system clock, byte-wide command stream from the debug wire deserialiser
// Notes: debug_control has no printed offset; it sits at a chosen address
// Operation
// - debug halt stops instruction fetch; code keeps fetch running while ocd_exec_req is high
// - system clock keeps running unless stopped
// - enabled peripherals keep running unless stopped
// - entering debug leaves halt low-power state
// - watchdog refreshed continuously while in debug
// - breakpoint execution enters debug state
// - debug pin low at reset end enters debug
// - writing zero to flag exits debug
// - power-on or brown-out reset exits debug
// - read program memory: code, address, size
// - size zero means 65536 bytes
// - program read gives FFH unless debug, unprotected
// - data write discarded unless debug, unprotected
// - data read gives FFH outside debug
// - CRC command returns CCITT checksum of program
// - CRC gives FFFFH outside debug
// - CRC reply comes after memory scan delay
// - control register layout, resets to zero
// - protected flag cannot be cleared by write
// - breakpoint is no-op unless allowed
// - acknowledge byte FFH sent on breakpoint; code sends it only if the engine is idle with tx free, else drops it
// - self-reset bit resets system, clears itself
`ifndef DMD_DEFINES_SVH
`define DMD_DEFINES_SVH
`define DMD_ADDR_CTRL     8'h00
`define DMD_ADDR_STATUS   8'h01
`define DMD_BIT_HALT      7
`define DMD_BIT_BRK       6
`define DMD_BIT_ACK       5
`define DMD_BIT_SRST      0
`define DMD_CTRL_RESET    8'h00
`define DMD_CMD_RD_PROG   8'h0B
`define DMD_CMD_WR_DATA   8'h0C
`define DMD_CMD_RD_DATA   8'h0D
`define DMD_CMD_CRC       8'h0E
`define DMD_FILL_BYTE     8'hFF
`define DMD_CRC_NONE      16'hFFFF
`define DMD_CRC_SEED      16'hFFFF
`define DMD_CRC_POLY      16'h1021
`define DMD_SRST_CYCLES   16
`endif

// ### shared/dmd_pkg.sv
// Purpose: types for the debug-mode memory access block
// Assumes: nothing beyond the defines header
// Notes: states are encoded 0 to 8 in declaration order, as read back through the status register
package dmd_pkg;
    typedef enum logic [3:0] {
        DMD_IDLE, DMD_AH, DMD_AL, DMD_SH, DMD_SL,
        DMD_XFER, DMD_CRC_RUN, DMD_CRC_HI, DMD_CRC_LO
    } dmd_state_e;
endpackage

// ### testbench/dmd_core_asserts.sv
// Purpose: port-level checks for dmd_core
// Assumes: ce tied high by the bench
// Notes: memory timing follows the one-cycle read answer
`timescale 1ns/1ps
// ==== checker
module dmd_core_asserts #(
    parameter int PROG_AW = 12
)(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        stop_mode,
    input wire logic        wdt_enable,
    input wire logic        ocd_exec_req,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [15:0] mem_addr,
    input wire logic        prog_rd,
    input wire logic        data_rd,
    input wire logic        fetch_enable,
    input wire logic        sys_clk_run,
    input wire logic        periph_run,
    input wire logic        halt_exit,
    input wire logic        wdt_refresh,
    input wire logic        soft_reset_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_clock_runs: assert property (sys_clk_run == !$past(stop_mode))
        else $error("system clock run flag disagrees with stop mode");
    chk_periph_runs: assert property (periph_run == sys_clk_run)
        else $error("peripheral run flag differs from clock run flag");
    chk_wdt_cause: assert property (wdt_refresh |-> $past(wdt_enable))
        else $error("watchdog refreshed while disabled");
    chk_fetch_idle: assert property (wdt_refresh && !$past(ocd_exec_req) |-> !fetch_enable)
        else $error("fetch running while in debug halt");
    chk_exit_pulse: assert property (halt_exit |=> !halt_exit)
        else $error("halt exit longer than one cycle");
    chk_exit_fetch: assert property (halt_exit |-> ##[0:1] !fetch_enable)
        else $error("halt exit without fetch stopping");
    chk_prog_pulse: assert property (prog_rd |=> !prog_rd)
        else $error("program read strobe longer than one cycle");
    chk_read_answer: assert property (data_rd |-> ##2 tx_valid)
        else $error("data byte not offered two cycles after read");
    chk_addr_step: assert property (data_rd |-> ##2 mem_addr == $past(mem_addr, 2) + 16'h0001)
        else $error("address did not step by one");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("tx byte dropped or changed while stalled");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    chk_srst_ends: assert property ($rose(soft_reset_out) |-> ##[1:20] !soft_reset_out)
        else $error("self reset did not clear itself");
    cover property (halt_exit);
    cover property (data_rd ##2 tx_valid && !tx_ready);
    cover property ($rose(soft_reset_out));
endmodule
bind dmd_core dmd_core_asserts #(.PROG_AW(PROG_AW)) dmd_core_asserts_inst (
    .clk(clk), .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .wdt_enable(wdt_enable), .ocd_exec_req(ocd_exec_req),
    .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .mem_addr(mem_addr), .prog_rd(prog_rd),
    .data_rd(data_rd), .fetch_enable(fetch_enable), .sys_clk_run(sys_clk_run),
    .periph_run(periph_run), .halt_exit(halt_exit), .wdt_refresh(wdt_refresh),
    .soft_reset_out(soft_reset_out));

// ### testbench/dmd_host_model.sv
// Purpose: debug host byte sink and memory stand-in for dmd_core
// Assumes: memories answer the cycle after a read strobe
// Notes: slow host takes a byte only every other cycle
`timescale 1ns/1ps
// ==== host and memories
module dmd_host_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [15:0] mem_addr,
    input  wire logic        prog_rd,
    output logic      [7:0]  prog_rdata,
    input  wire logic        data_rd,
    input  wire logic        data_wr,
    input  wire logic [7:0]  data_wdata,
    output logic      [7:0]  data_rdata
);
    logic [7:0] dmem [256];
    logic [7:0] got_q [$];
    logic       tog = 1'b0;
    assign tx_ready = !slow || tog;
    always @(posedge clk)
    begin
        tog <= !tog;
        if (tx_valid && tx_ready)
            got_q.push_back(tx_byte);
        if (data_wr)
            dmem[mem_addr[7:0]] <= data_wdata;
        // not-read cycles show a moving pattern, never the last byte
        prog_rdata <= prog_rd ? mem_addr[7:0] ^ 8'hA5 : ~(mem_addr[7:0] ^ 8'hA5);
        data_rdata <= data_rd ? dmem[mem_addr[7:0]] : mem_addr[7:0] ^ 8'h3C;
    end
endmodule

// ### testbench/tb_dmd_core.sv
// Purpose: self-checking bench for dmd_core
// Assumes: PROG_AW of 4 keeps the CRC scan short
// Notes: size-zero transfer only checked for staying open, not run to the end
`timescale 1ns/1ps
`include "dmd_defines.svh"
module tb_dmd_core;
    logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0;
    logic        por = 1'b0, srst_act = 1'b0, pin = 1'b1, stop = 1'b0, wdt_en = 1'b1;
    logic        exec = 1'b0;
    logic        prot = 1'b0, break_opcode = 1'b0, slow = 1'b0, tx_ready, tx_valid, prog_rd, data_rd;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rx_byte = 8'h00, reg_rdata, tx_byte;
    logic [7:0]  prog_rdata, data_wdata, data_rdata;
    logic [15:0] mem_addr, c;
    logic        data_wr, fetch_en, clk_run, per_run, halt_exit, wdt_ref, soft_rst;
    int          bad_count = 0, total_checks = 0;
    dmd_core #(.PROG_AW(4)) dmd_core_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .por_brownout(por), .sys_reset_active(srst_act),
        .debug_wire_pin_in(pin), .stop_mode(stop), .wdt_enable(wdt_en), .read_protect(prot),
        .break_opcode_decoded(break_opcode), .ocd_exec_req(exec), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .mem_addr(mem_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata), .data_rd(data_rd),
        .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata),
        .fetch_enable(fetch_en), .sys_clk_run(clk_run), .periph_run(per_run),
        .halt_exit(halt_exit), .wdt_refresh(wdt_ref), .soft_reset_out(soft_rst));
    dmd_host_model dmd_host_model_inst (.clk(clk), .slow(slow), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .mem_addr(mem_addr), .prog_rd(prog_rd),
        .prog_rdata(prog_rdata), .data_rd(data_rd), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rdata(data_rdata));
    always #20 clk = ~clk;
    // ==== tasks
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        reg_addr <= `DMD_ADDR_CTRL;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] e, input logic [7:0] a = `DMD_ADDR_CTRL);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    // host order: code, address high first, size high first
    task automatic cmd(input logic [7:0] k, input logic [15:0] a, input logic [15:0] n);
        send(k); send(a[15:8]); send(a[7:0]); send(n[15:8]); send(n[7:0]);
    endtask
    task automatic expect_tx(input logic [7:0] e);
        int k = 0;
        while (dmd_host_model_inst.got_q.size() == 0 && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        check("tx_byte", {8'h00, e}, k < 2000 ?
              {8'h00, dmd_host_model_inst.got_q.pop_front()} : 16'hxxxx);
    endtask
    task automatic pulse_brk;
        @(posedge clk);
        break_opcode <= 1'b1;
        @(posedge clk);
        break_opcode <= 1'b0;
    endtask
    function automatic logic [15:0] crc16(input int n);
        logic [15:0] r = `DMD_CRC_SEED;
        for (int a = 0; a < n; a++)
        begin
            r = r ^ {8'(a) ^ 8'hA5, 8'h00};
            for (int b = 0; b < 8; b++)
                r = r[15] ? (r << 1) ^ 16'h1021 : r << 1;
        end
        return r;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    // ==== tests
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h00);
        wr(8'h7E);
        rd(8'h60);
        cmd(`DMD_CMD_RD_PROG, 16'h0010, 16'h0002);
        for (int i = 0; i < 2; i++) expect_tx(8'hFF);
        pulse_brk();
        #1 check("halt_exit", 16'h0001, {15'h0, halt_exit});
        expect_tx(8'hFF);
        rd(8'hE0);
        check("fetch_wdt", 16'h0001, {14'h0, fetch_en, wdt_ref});
        exec <= 1'b1;
        wdt_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("exec_fetch_wdt", 16'h0002, {14'h0, fetch_en, wdt_ref});
        @(posedge clk);
        exec <= 1'b0;
        wdt_en <= 1'b1;
        slow <= 1'b1;
        cmd(`DMD_CMD_RD_PROG, 16'h0010, 16'h0003);
        for (int i = 0; i < 3; i++) expect_tx(8'h10 + 8'(i) ^ 8'hA5);
        cmd(`DMD_CMD_WR_DATA, 16'h0020, 16'h0002);
        send(8'hAA);
        send(8'h55);
        cmd(`DMD_CMD_RD_DATA, 16'h0020, 16'h0002);
        expect_tx(8'hAA);
        expect_tx(8'h55);
        slow <= 1'b0;
        prot <= 1'b1;
        cmd(`DMD_CMD_RD_PROG, 16'h0010, 16'h0001);
        expect_tx(8'hFF);
        cmd(`DMD_CMD_WR_DATA, 16'h0020, 16'h0001);
        send(8'h11);
        cmd(`DMD_CMD_RD_DATA, 16'h0020, 16'h0001);
        expect_tx(8'hAA);
        wr(8'h00);
        rd(8'h80);
        prot <= 1'b0;
        c = crc16(16);
        send(`DMD_CMD_CRC);
        expect_tx(c[15:8]);
        expect_tx(c[7:0]);
        wr(8'h00);
        rd(8'h00);
        send(`DMD_CMD_CRC);
        for (int i = 0; i < 2; i++) expect_tx(8'hFF);
        cmd(`DMD_CMD_RD_DATA, 16'h0020, 16'h0001);
        expect_tx(8'hFF);
        pulse_brk();
        rd(8'h00);
        wr(8'h80);
        @(posedge clk);
        por <= 1'b1;
        @(posedge clk);
        por <= 1'b0;
        rd(8'h00);
        @(posedge clk);
        srst_act <= 1'b1;
        pin <= 1'b0;
        repeat (3) @(posedge clk);
        srst_act <= 1'b0;
        pin <= 1'b1;
        rd(8'h80);
        wr(8'h81);
        @(posedge clk);
        #1 check("soft_reset_out", 16'h0001, {15'h0, soft_rst});
        repeat (20) @(posedge clk);
        rd(8'h80);
        cmd(`DMD_CMD_WR_DATA, 16'h0030, 16'h0000);
        send(8'h77);
        rd(8'(dmd_pkg::DMD_XFER), `DMD_ADDR_STATUS);
        @(posedge clk);
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("clk_periph_run", 16'h0000, {14'h0, clk_run, per_run});
        report_and_stop();
    end
endmodule
